// *** core/ppr_regulator.sv ***
`timescale 1ns/100ps
module ppr_regulator #(
  parameter int UPDATE_CYCLES = ppr_pkg::UPDATE_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        config_load_in,
  input  wire logic [2:0]  setpoint_source_select_in,
  input  wire logic [15:0] digital_setpoint_value_in,
  input  wire logic [15:0] setpoint_ramp_time_in,
  input  wire logic [3:0]  feedback_source_select_in,
  input  wire logic        action_direction_select_in,
  input  wire logic [15:0] display_full_scale_in,
  input  wire logic [15:0] first_prop_gain_in,
  input  wire logic [15:0] first_integ_time_in,
  input  wire logic [15:0] first_deriv_time_in,
  input  wire logic [15:0] second_prop_gain_in,
  input  wire logic [15:0] second_integ_time_in,
  input  wire logic [15:0] second_deriv_time_in,
  input  wire logic [1:0]  gain_switch_mode_in,
  input  wire logic [15:0] switch_threshold_low_in,
  input  wire logic [15:0] switch_threshold_high_in,
  input  wire logic [7:0]  integral_property_in,
  input  wire logic [15:0] analog_input_one_in,
  input  wire logic [15:0] analog_input_two_in,
  input  wire logic [15:0] analog_input_three_in,
  input  wire logic [15:0] pulse_capable_input_in,
  input  wire logic [15:0] high_speed_pulse_input_in,
  input  wire logic [15:0] comm_setpoint_in,
  input  wire logic [15:0] comm_feedback_in,
  input  wire logic [15:0] preset_setpoint_in,
  input  wire logic        direction_invert_in,
  input  wire logic        gain_set_select_in,
  input  wire logic        integral_pause_in,
  output logic      [15:0] freq_correction_out,
  output logic      [15:0] setpoint_display_out,
  output logic      [15:0] feedback_display_out,
  output logic             update_strobe_out,
  output logic             integ_frozen_out
);

  typedef struct packed {
    ppr_pkg::ppr_cfg_t  cfg;
    logic [31:0]        cnt;
    logic               tick;
    logic [15:0]        fb_prev;
    logic signed [31:0] integ;
    logic               sat;
    logic               frozen;
    logic signed [15:0] corr;
    logic [15:0]        sp_disp;
    logic [15:0]        fb_disp;
  } ppr_reg_state_t;

  localparam logic [31:0] LAST_CNT = 32'(UPDATE_CYCLES - 1);

  ppr_reg_state_t     st_reg;
  ppr_reg_state_t     st_next;
  logic [15:0]        sp_tgt;
  logic [15:0]        sp_ramp;
  logic [15:0]        fb;
  logic signed [16:0] err;
  logic               invert;
  logic               pause;
  logic               freeze;

  ppr_gain_if gi ();

  // ==========================================================
  // Helpers
  function automatic logic [15:0] clamp_pct(input logic [16:0] v);
    clamp_pct = (v > {1'b0, ppr_pkg::PCT_FULL}) ? ppr_pkg::PCT_FULL
                : v[15:0];
  endfunction

  function automatic logic [15:0] to_disp(input logic [15:0] pct,
                                          input logic [15:0] fs);
    logic [31:0] prod;
    prod = {16'h0000, pct} * {16'h0000, fs};
    to_disp = 16'(prod / {16'h0000, ppr_pkg::PCT_FULL});
  endfunction

  // ==========================================================
  // Setpoint channel
  always_comb begin
    case (st_reg.cfg.sp_sel)
      ppr_pkg::SP_DIGITAL: sp_tgt = st_reg.cfg.dig_sp;
      ppr_pkg::SP_AIN1:    sp_tgt = clamp_pct({1'b0, analog_input_one_in});
      ppr_pkg::SP_AIN2:    sp_tgt = clamp_pct({1'b0, analog_input_two_in});
      ppr_pkg::SP_AIN3:    sp_tgt = clamp_pct({1'b0, analog_input_three_in});
      ppr_pkg::SP_PULSE:   sp_tgt = clamp_pct({1'b0, pulse_capable_input_in});
      ppr_pkg::SP_COMM:    sp_tgt = clamp_pct({1'b0, comm_setpoint_in});
      ppr_pkg::SP_PRESET:  sp_tgt = clamp_pct({1'b0, preset_setpoint_in});
      default:             sp_tgt = st_reg.cfg.dig_sp;
    endcase
  end

  ppr_ramp u_ramp (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .tick_in      (st_reg.tick),
    .target_in    (sp_tgt),
    .ramp_time_in (st_reg.cfg.ramp_time),
    .value_out    (sp_ramp)
  );

  // ==========================================================
  // Feedback channel
  always_comb begin
    case (st_reg.cfg.fb_sel)
      ppr_pkg::FB_AIN1:  fb = clamp_pct({1'b0, analog_input_one_in});
      ppr_pkg::FB_AIN2:  fb = clamp_pct({1'b0, analog_input_two_in});
      ppr_pkg::FB_AIN3:  fb = clamp_pct({1'b0, analog_input_three_in});
      ppr_pkg::FB_PULSE: fb = clamp_pct({1'b0, high_speed_pulse_input_in});
      ppr_pkg::FB_DIFF:  fb = (analog_input_one_in > analog_input_two_in) ?
          clamp_pct({1'b0, analog_input_one_in - analog_input_two_in}) :
          16'h0000;
      ppr_pkg::FB_SUM:   fb = clamp_pct({1'b0, analog_input_one_in} +
                                        {1'b0, analog_input_two_in});
      ppr_pkg::FB_MAX:   fb = clamp_pct({1'b0,
          (analog_input_one_in > analog_input_two_in) ?
          analog_input_one_in : analog_input_two_in});
      ppr_pkg::FB_MIN:   fb = clamp_pct({1'b0,
          (analog_input_one_in < analog_input_two_in) ?
          analog_input_one_in : analog_input_two_in});
      ppr_pkg::FB_COMM:  fb = clamp_pct({1'b0, comm_feedback_in});
      default:           fb = clamp_pct({1'b0, analog_input_one_in});
    endcase
  end

  // ==========================================================
  // Error, direction and gain selection
  assign err    = $signed({1'b0, sp_ramp}) - $signed({1'b0, fb});
  assign invert = st_reg.cfg.dir ^ direction_invert_in;
  assign pause  = (st_reg.cfg.integ_prop[3:0] == 4'h1) &&
                  integral_pause_in;
  assign freeze = (st_reg.cfg.integ_prop[7:4] == 4'h1) &&
                  st_reg.sat;

  assign gi.set_one  = st_reg.cfg.set_one;
  assign gi.set_two  = st_reg.cfg.set_two;
  assign gi.abs_err  = err[16] ? 16'(-err) : err[15:0];
  assign gi.thr_low  = st_reg.cfg.thr_low;
  assign gi.thr_high = st_reg.cfg.thr_high;
  assign gi.mode     = st_reg.cfg.sw_mode;
  assign gi.sel      = gain_set_select_in;

  ppr_gain_blend u_blend (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .gi      (gi)
  );

  // ==========================================================
  // State update
  always_comb begin
    logic signed [16:0] e_eff;
    logic signed [16:0] dfb;
    logic signed [33:0] p_t;
    logic signed [33:0] d_t;
    logic signed [47:0] inc;
    logic [18:0]        tden;
    logic signed [32:0] acc;
    logic signed [35:0] sum;
    e_eff   = 17'sd0;
    dfb     = 17'sd0;
    p_t     = 34'sd0;
    d_t     = 34'sd0;
    inc     = 48'sd0;
    tden    = 19'h00001;
    acc     = 33'sd0;
    sum     = 36'sd0;
    st_next = st_reg;

    if (config_load_in) begin
      st_next.cfg.sp_sel     = setpoint_source_select_in;
      st_next.cfg.dig_sp     = clamp_pct({1'b0, digital_setpoint_value_in});
      st_next.cfg.ramp_time  = setpoint_ramp_time_in;
      st_next.cfg.fb_sel     = feedback_source_select_in;
      st_next.cfg.dir        = action_direction_select_in;
      st_next.cfg.full_scale = display_full_scale_in;
      st_next.cfg.set_one    = {first_deriv_time_in,
          (first_integ_time_in == 16'h0000) ? 16'h0001 : first_integ_time_in,
          first_prop_gain_in};
      st_next.cfg.set_two    = {second_deriv_time_in,
          (second_integ_time_in == 16'h0000) ? 16'h0001 : second_integ_time_in,
          second_prop_gain_in};
      st_next.cfg.sw_mode    = gain_switch_mode_in;
      st_next.cfg.thr_low    = switch_threshold_low_in;
      st_next.cfg.thr_high   = switch_threshold_high_in;
      st_next.cfg.integ_prop = integral_property_in;
    end

    st_next.tick = (st_reg.cnt == LAST_CNT);
    st_next.cnt  = st_next.tick ? 32'h00000000 : st_reg.cnt + 32'h00000001;

    if (st_reg.tick) begin
      e_eff = invert ? -err : err;
      dfb   = invert ? $signed({1'b0, fb}) - $signed({1'b0, st_reg.fb_prev})
                     : $signed({1'b0, st_reg.fb_prev}) - $signed({1'b0, fb});
      p_t   = $signed({e_eff[16], e_eff}) * $signed({1'b0, gi.blended[0]})
              / 34'(ppr_pkg::KP_DIV);
      d_t   = $signed({dfb[16], dfb}) * $signed({1'b0, gi.blended[2]})
              / 34'(ppr_pkg::DERIV_RATIO);
      tden  = 19'({3'b000, gi.blended[1]} * 19'(ppr_pkg::RAMP_RATIO));
      inc   = $signed({{15{e_eff[16]}}, e_eff, 16'h0000}) /
              $signed({29'h0, tden});
      acc   = {st_reg.integ[31], st_reg.integ};
      if (!pause && !freeze) begin
        acc = acc + 33'(inc);
        if (acc > $signed({1'b0, ppr_pkg::INTEG_LIMIT})) begin
          acc = $signed({1'b0, ppr_pkg::INTEG_LIMIT});
        end else if (acc < -$signed({1'b0, ppr_pkg::INTEG_LIMIT})) begin
          acc = -$signed({1'b0, ppr_pkg::INTEG_LIMIT});
        end
      end
      st_next.integ  = acc[31:0];
      st_next.frozen = pause || freeze;
      sum = 36'(p_t) + 36'(d_t);
      if (!pause) begin
        sum = sum + 36'(acc >>> 16);
      end
      if (sum > $signed({20'h0, ppr_pkg::PCT_FULL})) begin
        st_next.corr = $signed(ppr_pkg::PCT_FULL);
        st_next.sat  = 1'b1;
      end else if (sum < -$signed({20'h0, ppr_pkg::PCT_FULL})) begin
        st_next.corr = -$signed(ppr_pkg::PCT_FULL);
        st_next.sat  = 1'b1;
      end else begin
        st_next.corr = sum[15:0];
        st_next.sat  = 1'b0;
      end
      st_next.fb_prev = fb;
      st_next.sp_disp = to_disp(sp_ramp, st_reg.cfg.full_scale);
      st_next.fb_disp = to_disp(fb, st_reg.cfg.full_scale);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg                <= '0;
      st_reg.cfg.sp_sel     <= ppr_pkg::SP_SEL_RST;
      st_reg.cfg.dig_sp     <= ppr_pkg::DIG_SP_RST;
      st_reg.cfg.ramp_time  <= ppr_pkg::RAMP_TIME_RST;
      st_reg.cfg.fb_sel     <= ppr_pkg::FB_SEL_RST;
      st_reg.cfg.dir        <= ppr_pkg::DIR_RST;
      st_reg.cfg.full_scale <= ppr_pkg::FULL_SCALE_RST;
      st_reg.cfg.set_one    <= {ppr_pkg::TD_RST, ppr_pkg::TI_RST,
                                ppr_pkg::KP_RST};
      st_reg.cfg.set_two    <= {ppr_pkg::TD_RST, ppr_pkg::TI_RST,
                                ppr_pkg::KP_RST};
      st_reg.cfg.sw_mode    <= ppr_pkg::SW_MODE_RST;
      st_reg.cfg.thr_low    <= ppr_pkg::THR_LOW_RST;
      st_reg.cfg.thr_high   <= ppr_pkg::THR_HIGH_RST;
      st_reg.cfg.integ_prop <= ppr_pkg::INTEG_PROP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign freq_correction_out  = st_reg.corr;
  assign setpoint_display_out = st_reg.sp_disp;
  assign feedback_display_out = st_reg.fb_disp;
  assign update_strobe_out    = st_reg.tick;
  assign integ_frozen_out     = st_reg.frozen;

  // ==========================================================
  // Checks
  a_corr_in_range: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ($signed(st_reg.corr) <= $signed(ppr_pkg::PCT_FULL)) &&
    ($signed(st_reg.corr) >= -$signed(ppr_pkg::PCT_FULL)))
    else $error("correction beyond maximum frequency");

  a_tick_period: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    st_reg.tick |-> ($past(st_reg.cnt) == LAST_CNT))
    else $error("update strobe off period");

  a_corr_holds: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !st_reg.tick |=> $stable(st_reg.corr))
    else $error("correction changed between updates");

  a_integ_paused: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (st_reg.tick && pause) |=> ($stable(st_reg.integ) && st_reg.frozen))
    else $error("integral moved while paused");

  a_integ_freeze: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (st_reg.tick && freeze) |=> $stable(st_reg.integ))
    else $error("integral moved at limit with freeze");

  a_dig_sp_range: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    config_load_in |=> (st_reg.cfg.dig_sp <= ppr_pkg::PCT_FULL))
    else $error("digital setpoint above full scale");

  a_forward_rise: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (st_reg.tick && !invert && err > 0 && !pause &&
     st_reg.integ >= 0 && gi.blended[2] == 16'h0000) |=>
      ($signed(st_reg.corr) >= 0))
    else $error("forward action did not raise frequency");

  a_reverse_fall: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (st_reg.tick && invert && err > 0 && !pause &&
     st_reg.integ <= 0 && gi.blended[2] == 16'h0000) |=>
      ($signed(st_reg.corr) <= 0))
    else $error("reverse action did not lower frequency");
endmodule

// *** core/ppr_pkg.sv ***
package ppr_pkg;

  // ==========================================================
  // Scaling, percent values in 0.01 % units
  localparam logic [15:0] PCT_FULL       = 16'h2710;
  localparam logic [31:0] INTEG_LIMIT    = 32'h27100000;
  localparam int          KP_DIV         = 1000;
  localparam int          BLEND_ONE      = 256;
  localparam int          BLEND_BITS     = 8;

  // ==========================================================
  // Timing
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          UPDATE_PERIOD_NS  = 2000000;
  localparam int          UPDATE_CYCLES     = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          TIME_UNIT_NS      = 10000000;
  localparam int          DERIV_UNIT_NS     = 1000000;
  localparam int          RAMP_RATIO        = TIME_UNIT_NS / UPDATE_PERIOD_NS;
  localparam int          DERIV_RATIO       = UPDATE_PERIOD_NS / DERIV_UNIT_NS;
  localparam int          RAMP_STEP_NUM     = 10000 * 65536 / RAMP_RATIO;

  // ==========================================================
  // Reset values of settings
  localparam logic [2:0]  SP_SEL_RST      = 3'h0;
  localparam logic [15:0] DIG_SP_RST      = 16'h1388;
  localparam logic [15:0] RAMP_TIME_RST   = 16'h0000;
  localparam logic [3:0]  FB_SEL_RST      = 4'h0;
  localparam logic        DIR_RST         = 1'b0;
  localparam logic [15:0] FULL_SCALE_RST  = 16'h03E8;
  localparam logic [15:0] KP_RST          = 16'h07D0;
  localparam logic [15:0] TI_RST          = 16'h00C8;
  localparam logic [15:0] TD_RST          = 16'h0000;
  localparam logic [1:0]  SW_MODE_RST     = 2'h0;
  localparam logic [15:0] THR_LOW_RST     = 16'h07D0;
  localparam logic [15:0] THR_HIGH_RST    = 16'h1F40;
  localparam logic [7:0]  INTEG_PROP_RST  = 8'h00;

  // ==========================================================
  // Select codes
  localparam logic [2:0]  SP_DIGITAL  = 3'h0;
  localparam logic [2:0]  SP_AIN1     = 3'h1;
  localparam logic [2:0]  SP_AIN2     = 3'h2;
  localparam logic [2:0]  SP_AIN3     = 3'h3;
  localparam logic [2:0]  SP_PULSE    = 3'h4;
  localparam logic [2:0]  SP_COMM     = 3'h5;
  localparam logic [2:0]  SP_PRESET   = 3'h6;
  localparam logic [3:0]  FB_AIN1     = 4'h0;
  localparam logic [3:0]  FB_AIN2     = 4'h1;
  localparam logic [3:0]  FB_AIN3     = 4'h2;
  localparam logic [3:0]  FB_PULSE    = 4'h3;
  localparam logic [3:0]  FB_DIFF     = 4'h4;
  localparam logic [3:0]  FB_SUM      = 4'h5;
  localparam logic [3:0]  FB_MAX      = 4'h6;
  localparam logic [3:0]  FB_MIN      = 4'h7;
  localparam logic [3:0]  FB_COMM     = 4'h8;
  localparam logic [1:0]  SW_NONE     = 2'h0;
  localparam logic [1:0]  SW_INPUT    = 2'h1;
  localparam logic [1:0]  SW_AUTO     = 2'h2;

  typedef struct packed {
    logic [2:0]  sp_sel;
    logic [15:0] dig_sp;
    logic [15:0] ramp_time;
    logic [3:0]  fb_sel;
    logic        dir;
    logic [15:0] full_scale;
    logic [2:0][15:0] set_one;
    logic [2:0][15:0] set_two;
    logic [1:0]  sw_mode;
    logic [15:0] thr_low;
    logic [15:0] thr_high;
    logic [7:0]  integ_prop;
  } ppr_cfg_t;

endpackage

// *** core/ppr_gain_if.sv ***
`timescale 1ns/100ps
interface ppr_gain_if;
  logic [2:0][15:0] set_one;
  logic [2:0][15:0] set_two;
  logic [2:0][15:0] blended;
  logic [15:0]      abs_err;
  logic [15:0]      thr_low;
  logic [15:0]      thr_high;
  logic [1:0]       mode;
  logic             sel;

  modport user  (output set_one, set_two, abs_err, thr_low, thr_high,
                 mode, sel, input blended);
  modport blend (input set_one, set_two, abs_err, thr_low, thr_high,
                 mode, sel, output blended);
endinterface

// *** core/ppr_ramp.sv ***
`timescale 1ns/100ps
module ppr_ramp (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        tick_in,
  input  wire logic [15:0] target_in,
  input  wire logic [15:0] ramp_time_in,
  output logic      [15:0] value_out
);
  typedef struct packed {
    logic [31:0] acc;
  } ppr_ramp_state_t;

  ppr_ramp_state_t st_reg;
  ppr_ramp_state_t st_next;
  logic [31:0]     step;
  logic [31:0]     tgt;

  assign tgt  = {target_in, 16'h0000};
  assign step = (ramp_time_in == 16'h0000) ? 32'h00000000 :
                32'(ppr_pkg::RAMP_STEP_NUM) / {16'h0000, ramp_time_in};

  // ==========================================================
  // Linear approach to target
  always_comb begin
    st_next = st_reg;
    if (tick_in) begin
      if (ramp_time_in == 16'h0000) begin
        st_next.acc = tgt;
      end else if (st_reg.acc < tgt) begin
        st_next.acc = (tgt - st_reg.acc > step) ? st_reg.acc + step : tgt;
      end else begin
        st_next.acc = (st_reg.acc - tgt > step) ? st_reg.acc - step : tgt;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign value_out = st_reg.acc[31:16];

  a_ramp_jump_zero: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (tick_in && ramp_time_in == 16'h0000) |=> (value_out == $past(target_in)))
    else $error("ramp did not jump with zero ramp time");

  a_ramp_step_limit: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (tick_in && ramp_time_in != 16'h0000) |=>
      ((st_reg.acc >= $past(st_reg.acc) ?
        st_reg.acc - $past(st_reg.acc) :
        $past(st_reg.acc) - st_reg.acc) <= $past(step)))
    else $error("ramp moved more than one step");
endmodule

// *** core/ppr_gain_blend.sv ***
`timescale 1ns/100ps
module ppr_gain_blend (
  input  wire logic   clk_in,
  input  wire logic   nrst_in,
  ppr_gain_if.blend   gi
);
  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] span;
  logic [8:0]  w;
  logic [23:0] frac;

  // ==========================================================
  // Threshold ordering and blend weight
  assign hi   = (gi.thr_high > ppr_pkg::PCT_FULL) ? ppr_pkg::PCT_FULL
                : gi.thr_high;
  assign lo   = (gi.thr_low > hi) ? hi : gi.thr_low;
  assign span = hi - lo;
  assign frac = ({8'h00, gi.abs_err - lo} << ppr_pkg::BLEND_BITS)
                / {8'h00, span};

  always_comb begin
    w = 9'h000;
    case (gi.mode)
      ppr_pkg::SW_INPUT: w = gi.sel ? 9'h100 : 9'h000;
      ppr_pkg::SW_AUTO: begin
        if (gi.abs_err <= lo) begin
          w = 9'h000;
        end else if (gi.abs_err >= hi) begin
          w = 9'h100;
        end else begin
          w = frac[8:0];
        end
      end
      default: w = 9'h000;
    endcase
  end

  // ==========================================================
  // One interpolator per gain
  for (genvar i = 0; i < 3; i++) begin : g_blend
    logic signed [17:0] diff;
    logic signed [27:0] prod;
    assign diff = $signed({2'b00, gi.set_two[i]}) -
                  $signed({2'b00, gi.set_one[i]});
    assign prod = diff * $signed({1'b0, w});
    assign gi.blended[i] = 16'($signed({2'b00, gi.set_one[i]}) +
                               18'(prod >>> ppr_pkg::BLEND_BITS));
  end

  a_blend_input_sel: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (gi.mode == ppr_pkg::SW_INPUT) |->
      (gi.blended == (gi.sel ? gi.set_two : gi.set_one)))
    else $error("input-driven gain set mismatch");

  a_blend_auto_edge: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (gi.mode == ppr_pkg::SW_AUTO && gi.abs_err >= hi) |->
      (gi.blended == gi.set_two))
    else $error("high error did not select set two");
endmodule

// *** dv/ppr_src_model.sv ***
`timescale 1ns/100ps
module ppr_src_model (
  input  wire logic [15:0]      base_in,
  output logic      [7:0][15:0] src_out
);
  // ==========================================
  // Channel levels derived from one base level, except channels 3, 5 and 7, which are fixed
  always_comb begin
    src_out[0] = base_in;
    src_out[1] = base_in >> 1;
    src_out[2] = 16'h2710 - base_in;
    src_out[3] = 16'h04D2;
    src_out[4] = base_in >> 2;
    src_out[5] = 16'h10E1;
    src_out[6] = base_in >> 3;
    src_out[7] = 16'h1E61;
  end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/100ps
module tb;
  logic clk_in, nrst_in, config_load_in, action_direction_select_in;
  logic direction_invert_in, gain_set_select_in, integral_pause_in;
  logic [2:0] setpoint_source_select_in;
  logic [3:0] feedback_source_select_in;
  logic [1:0] gain_switch_mode_in;
  logic [7:0] integral_property_in;
  logic [15:0] digital_setpoint_value_in, setpoint_ramp_time_in;
  logic [15:0] display_full_scale_in, first_prop_gain_in;
  logic [15:0] first_integ_time_in, first_deriv_time_in;
  logic [15:0] second_prop_gain_in, second_integ_time_in;
  logic [15:0] second_deriv_time_in, switch_threshold_low_in;
  logic [15:0] switch_threshold_high_in, analog_input_one_in;
  logic [15:0] analog_input_two_in, analog_input_three_in;
  logic [15:0] pulse_capable_input_in, high_speed_pulse_input_in;
  logic [15:0] comm_setpoint_in, comm_feedback_in, preset_setpoint_in;
  logic [15:0] freq_correction_out, setpoint_display_out;
  logic [15:0] feedback_display_out, base;
  logic update_strobe_out, integ_frozen_out;
  logic [7:0][15:0] src;
  int err_total = 0;
  int compares = 0;
  ppr_regulator #(.UPDATE_CYCLES(20)) ppr_regulator_i (.*);
  ppr_src_model ppr_src_model_i (.base_in(base), .src_out(src));
  assign {preset_setpoint_in, comm_feedback_in, comm_setpoint_in,
          high_speed_pulse_input_in, pulse_capable_input_in,
          analog_input_three_in, analog_input_two_in,
          analog_input_one_in} = src;
  // ==========================================
  // Expectations, checks and timing
  function automatic logic [15:0] sp_exp(input logic [2:0] s);
    case (s)
      3'h1, 3'h2, 3'h3, 3'h5: return src[s - 3'h1 + (s == 3'h5)];
      3'h4: return src[3];
      3'h6: return src[7];
      default: return digital_setpoint_value_in;
    endcase
  endfunction
  function automatic logic [15:0] fb_exp(input logic [3:0] s);
    logic [15:0] a = src[0];
    logic [15:0] b = src[1];
    case (s)
      4'h0, 4'h1, 4'h2: return src[s];
      4'h3: return src[4];
      4'h4: return (a > b) ? a - b : 16'h0000;
      4'h5: return (a + b > 16'h2710) ? 16'h2710 : a + b;
      4'h6: return (a > b) ? a : b;
      4'h7: return (a < b) ? a : b;
      4'h8: return src[6];
      default: return src[0];
    endcase
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic upd(input int n);
    repeat (n) begin
      do @(negedge clk_in); while (update_strobe_out !== 1'b1);
      @(negedge clk_in);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk_in = 0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #2000000 err_total++;
    results();
  end
  initial begin
    void'($urandom(94));
    {nrst_in, config_load_in, action_direction_select_in, direction_invert_in,
     gain_set_select_in, setpoint_source_select_in, feedback_source_select_in,
     gain_switch_mode_in, setpoint_ramp_time_in, first_deriv_time_in,
     second_deriv_time_in} = '0;
    {integral_pause_in, integral_property_in} = 9'h101;
    {first_prop_gain_in, second_prop_gain_in} = 32'h03E801F4;
    {first_integ_time_in, second_integ_time_in} = 32'h00C800C8;
    {switch_threshold_low_in, switch_threshold_high_in} = 32'h07D01F40;
    {digital_setpoint_value_in, display_full_scale_in} = 32'h13882710;
    base = 16'h07D0;
    repeat (3) @(negedge clk_in);
    nrst_in = 1;
    chk(freq_correction_out, 16'h0000);
    upd(2);
    chk(setpoint_display_out, 16'h01F4);
    $display("test defaults done");
    config_load_in = 1;
    for (int d = 0; d < 5; d++) begin
      action_direction_select_in = (d == 1);
      direction_invert_in = (d == 2);
      gain_switch_mode_in = (d > 2) ? 2'h1 : {d == 1, d == 1};
      gain_set_select_in = (d == 4 || d == 1);
      upd(2);
      chk(freq_correction_out, (d == 4) ? 16'h05DC : (d == 0 || d == 3) ?
          16'h0BB8 : 16'hF448);
    end
    $display("test direction and gain done");
    for (int s = 0; s < 10; s++) begin
      base = 16'($urandom % 10001);
      digital_setpoint_value_in = 16'($urandom % 10001);
      setpoint_source_select_in = 3'(s);
      feedback_source_select_in = 4'(s);
      upd(2);
      chk(setpoint_display_out, sp_exp(3'(s)));
      chk(feedback_display_out, fb_exp(4'(s)));
    end
    $display("test sources done");
    digital_setpoint_value_in = 16'h0000;
    setpoint_source_select_in = 3'h0;
    upd(2);
    setpoint_ramp_time_in = 16'h0001;
    digital_setpoint_value_in = 16'h2710;
    upd(2);
    chk(setpoint_display_out, 16'h07D0);
    upd(6);
    chk(setpoint_display_out, 16'h2710);
    $display("test ramp done");
    nrst_in = 0;
    {setpoint_ramp_time_in, first_prop_gain_in} = 32'h00000000;
    {first_integ_time_in, digital_setpoint_value_in} = 32'h000107D0;
    {gain_switch_mode_in, feedback_source_select_in} = 6'h00;
    integral_property_in = 8'h00;
    base = 16'h03E8;
    @(negedge clk_in);
    nrst_in = 1;
    chk(freq_correction_out, 16'h0000);
    chk({15'h0, integ_frozen_out}, 16'h0000);
    upd(3);
    chk(freq_correction_out, 16'h00C8);
    first_prop_gain_in = 16'hFFFF;
    integral_property_in = 8'h10;
    upd(2);
    chk(freq_correction_out, 16'h2710);
    chk({15'h0, integ_frozen_out}, 16'h0001);
    first_prop_gain_in = 16'h0000;
    upd(2);
    chk(freq_correction_out, 16'h0258);
    chk({15'h0, integ_frozen_out}, 16'h0000);
    integral_property_in = 8'h01;
    upd(1);
    chk(freq_correction_out, 16'h0000);
    chk({15'h0, integ_frozen_out}, 16'h0001);
    integral_property_in = 8'h00;
    upd(1);
    chk(freq_correction_out, 16'h0320);
    first_deriv_time_in = 16'h000A;
    base = 16'h044C;
    upd(1);
    chk(freq_correction_out, 16'h01E0);
    $display("test integral and derivative done");
    {gain_switch_mode_in, integral_property_in} = 10'h201;
    second_prop_gain_in = 16'h03E8;
    digital_setpoint_value_in = 16'h17D4;
    upd(2);
    chk(freq_correction_out, 16'h09C4);
    digital_setpoint_value_in = 16'h2710;
    upd(2);
    chk(freq_correction_out, 16'h22C4);
    $display("test automatic blend done");
    results();
  end
endmodule
